// *** core/ovp_brownout_protection.sv ***
// Purpose : output overvoltage and mains brownout protection sequencing
// Assumes : comparator inputs are synchronised here, one clock domain
// Notes   : analog sources and thresholds sit outside; this is the decision logic
`timescale 1ns/1ps

// Summary of operation
// [R1] overvoltage hit only during switch off-time
// [R2] sample 0.5us window starting 2us after turn-off
// [R3] stop after four consecutive hit cycles
// [R4] cycle without hit clears hit counter
// [R5] enable feedforward current source on overvoltage stop
// [R6] feedforward above escalation threshold latches off
// [R7] otherwise restart once supply below five volts
// [R8] before running, refuse start without mains upper
// [R9] while running, brownout below lower mains threshold
// [R10] brownout: fail flag, open switch, discharge, gate low
// [R11] latched off plus mains low clears latch
// [R12] brownout keeps startup generator cycling, no pulses
// [R13] mains current sink follows the fail flag
// [R14] latched off held until supply undervoltage lockout
// [R15] synchronise comparators, derive timing from clock counts
module ovp_brownout_protection
    import prot_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,

    // power switch timing
    input  wire logic gate_on,              // gate drive request from pwm

    // comparators (asynchronous levels)
    input  wire logic aux_winding_sense,    // aux sense above overvoltage ref
    input  wire logic feedforward_pin,      // feedforward above escalation level
    input  wire logic mains_above_upper,    // mains sense above upper threshold
    input  wire logic mains_below_lower,    // mains sense below lower threshold
    input  wire logic supply_below_5v,      // supply monitor below five volts
    input  wire logic supply_uvlo,          // supply below lockout threshold

    // protection outputs
    output logic      gate_enable,          // allows gate drive high
    output logic      gate_out,             // gated gate drive
    output logic      feedforward_source_en,// about 1 mA source on feedforward pin
    output logic      mains_fail_flag,      // brownout indication
    output logic      mains_sink_en,        // about 15 uA sink on mains sense pin
    output logic      pfc_supply_switch,    // closed when high
    output logic      softstart_discharge,  // discharge soft-start capacitor
    output logic      hv_startup_cycle,     // startup generator cycling, no pwm
    output logic      latched_off,          // protection latch status
    output logic      ovp_stopped           // overvoltage auto-restart stop
);

    // ****************************************
    // input synchronisers
    // ****************************************
    // two flops: tiny delay against 2 us
    localparam int NSYNC = 6;

    logic [NSYNC-1:0] async_in;             // raw comparator levels
    logic [NSYNC-1:0] meta_reg;             // first stage, read only by second
    logic [NSYNC-1:0] sync_reg;             // clean synchronous levels

    // bit order sets the taps
    assign async_in = {supply_uvlo, supply_below_5v, mains_below_lower,
                       mains_above_upper, feedforward_pin, aux_winding_sense};

    // two flops per comparator; metastability hazard on the first
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (srst) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    // first may settle late
                    meta_reg[gi] <= async_in[gi];   // [R15]
                    sync_reg[gi] <= meta_reg[gi];   // [R15]
                end
            end
        end
    endgenerate

    // synchronised levels
    logic aux_s;                            // aux sense synchronised
    logic ff_high_s;                        // feedforward over escalation

    logic mains_up_s;                       // above upper threshold
    logic mains_low_s;                      // below lower threshold
    logic vcc_low_s;                        // supply below five volts
    logic uvlo_s;                           // supply in lockout

    assign aux_s       = sync_reg[0];
    assign ff_high_s   = sync_reg[1];

    assign mains_up_s  = sync_reg[2];
    assign mains_low_s = sync_reg[3];
    assign vcc_low_s   = sync_reg[4];
    assign uvlo_s      = sync_reg[5];

    // ****************************************
    // turn-off detection and window timer
    // ****************************************
    // timer events
    gate_timing_if tmg ();

    logic gate_on_d_reg;                    // last gate level for edge detect

    // gate input is taken as synchronous, no synchroniser needed
    // resets to the idle gate: no false edge
    always_ff @(posedge clock) begin
        if (srst) begin
            gate_on_d_reg <= 1'b0;
        end else begin
            // last driven level
            gate_on_d_reg <= gate_out;
        end
    end

    // falling edge of the gate actually driven marks the off-time start
    // a stopped request edge is no turn-off
    assign tmg.turn_off_pulse = gate_on_d_reg & ~gate_out;

    // lengths from the package
    ovp_window_timer u_timer (
        .clock (clock),
        .srst  (srst),
        .tmg   (tmg)
    );

    // ****************************************
    // per-cycle hit capture and counting
    // ****************************************
    logic             hit_seen_reg;         // hit inside current window
    logic [HIT_W-1:0] hit_cnt_reg;          // consecutive hit cycles
    logic [HIT_W-1:0] hit_cnt_next;
    logic             ovp_trip;             // fourth consecutive hit

    prot_state_t      state_reg;            // current protection state
    prot_state_t      state_next;

    // compare only in the window while the switch is off
    always_ff @(posedge clock) begin
        if (srst) begin
            hit_seen_reg <= 1'b0;
        end else if (tmg.window_close | tmg.turn_off_pulse) begin
            // capture starts empty
            hit_seen_reg <= 1'b0;
        end else if (tmg.window_open && !gate_out && aux_s) begin   // [R1] [R2]
            // switch off, window open
            hit_seen_reg <= 1'b1;
        end
    end

    // count at each window end; a hit-free cycle restarts the count
    always_comb begin
        hit_cnt_next = hit_cnt_reg;

        if (tmg.window_close) begin
            if (hit_seen_reg) begin
                // one more hit cycle
                hit_cnt_next = (hit_cnt_reg == HIT_LIMIT) ? HIT_LIMIT
                                                           : hit_cnt_reg + HIT_W'(1);
            end else begin
                // clean window ends the run
                hit_cnt_next = HIT_RESET;                           // [R4]
            end
        end
    end

    // a turn-off that cuts a window short
    // leaves the count alone: no hit, no miss

    always_ff @(posedge clock) begin
        if (srst) begin
            hit_cnt_reg <= HIT_RESET;
        end else if (state_reg != ST_RUN) begin
            hit_cnt_reg <= HIT_RESET;       // fresh count after any stop
        end else begin
            // take the window result
            hit_cnt_reg <= hit_cnt_next;
        end
    end

    // holds until the stop clears it
    assign ovp_trip = (hit_cnt_reg == HIT_LIMIT);                   // [R3]

    // ****************************************
    // protection state machine
    // ****************************************
    // state_reg and state_next sit above

    // uvlo overrides everything; it and mains low are the two exits from the latch
    always_comb begin
        state_next = state_reg;

        unique case (state_reg)
            ST_BROWNOUT: begin
                // refuse start until mains above upper threshold
                if (mains_up_s && !mains_low_s) begin               // [R8]
                    state_next = ST_RUN;
                end
            end

            ST_RUN: begin
                // mains loss outranks a trip
                if (mains_low_s) begin
                    state_next = ST_BROWNOUT;                       // [R9]
                end else if (ovp_trip) begin
                    state_next = ST_OVP_STOP;                       // [R3]
                end
            end

            ST_OVP_STOP: begin
                // escalation first
                if (ff_high_s) begin
                    state_next = ST_LATCHED;                        // [R6]
                end else if (vcc_low_s) begin
                    // re-checks mains
                    state_next = ST_BROWNOUT;                       // [R7]
                end
            end

            ST_LATCHED: begin
                // mains removal clears the latch for a quick restart
                // lockout is the other exit
                if (mains_low_s) begin
                    state_next = ST_BROWNOUT;                       // [R11]
                end
            end
        endcase

        // lockout beats every state
        if (uvlo_s) begin
            state_next = ST_BROWNOUT;                               // [R14]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            // safe state, no pulses
            state_reg <= ST_BROWNOUT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    // from state_next: same edge
    logic fail_reg;                         // brownout flag
    logic src_reg;                          // feedforward source enable
    logic pfc_reg;                          // pfc supply switch closed

    // brownout flag tracks the state, before or during operation
    always_ff @(posedge clock) begin
        if (srst) begin
            fail_reg <= 1'b1;
        end else begin
            fail_reg <= (state_next == ST_BROWNOUT);                // [R10]
        end
    end

    // source only during the overvoltage stop, pulls feedforward up
    // the latch drops it again
    always_ff @(posedge clock) begin
        if (srst) begin
            src_reg <= 1'b0;
        end else begin
            src_reg <= (state_next == ST_OVP_STOP);                 // [R5]
        end
    end

    // pfc supply only while running
    // open in every other state
    always_ff @(posedge clock) begin
        if (srst) begin
            pfc_reg <= 1'b0;
        end else begin
            pfc_reg <= (state_next == ST_RUN);                      // [R10]
        end
    end

    // outputs; flag, sink and discharge mirror the fail flag
    assign mains_fail_flag       = fail_reg;                        // [R10]
    assign mains_sink_en         = fail_reg;                        // [R13]
    assign pfc_supply_switch     = pfc_reg;
    assign feedforward_source_en = src_reg;
    assign softstart_discharge   = fail_reg;                        // [R10]

    // startup generator cycles while no pwm is allowed
    assign hv_startup_cycle      = (state_reg != ST_RUN);           // [R12]

    // decoded from the state flops
    assign latched_off           = (state_reg == ST_LATCHED);
    assign ovp_stopped           = (state_reg == ST_OVP_STOP);

    // gate forced low in every state but run
    assign gate_enable           = (state_reg == ST_RUN);           // [R10] [R12]
    // combinational: no added delay
    assign gate_out              = gate_on & gate_enable;

endmodule

// *** core/prot_pkg.sv ***
// Purpose : shared constants for the overvoltage and brownout protection logic
// Assumes : 250 MHz core clock, comparator inputs already digital
// Notes   : times are in ns, cycle counts derive from them
package prot_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS     = 4;      // 250 MHz
    localparam int BLANK_DELAY_NS    = 2000;   // turn-off to window start
    localparam int SAMPLE_WINDOW_NS  = 500;    // window length
    // least time rounds up, longest time rounds down, never below one cycle
    localparam int BLANK_CYCLES_I    = (BLANK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WINDOW_CYCLES_I   = (SAMPLE_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                       (SAMPLE_WINDOW_NS / CLK_PERIOD_NS);
    localparam int TIMER_W           = 10;
    localparam logic [TIMER_W-1:0] BLANK_CYCLES  = TIMER_W'(BLANK_CYCLES_I);
    localparam logic [TIMER_W-1:0] WINDOW_CYCLES = TIMER_W'(WINDOW_CYCLES_I);

    // ****************************************
    // hit counting
    // ****************************************
    localparam int HIT_W             = 3;
    localparam logic [HIT_W-1:0] HIT_LIMIT = 3'h4;  // consecutive cycles to trip
    localparam logic [HIT_W-1:0] HIT_RESET = 3'h0;

    // ****************************************
    // protection state
    // ****************************************
    typedef enum logic [1:0] {
        ST_BROWNOUT  = 2'b00,   // waiting for mains, no switching
        ST_RUN       = 2'b01,   // normal operation
        ST_OVP_STOP  = 2'b10,   // overvoltage stop, auto-restart pending
        ST_LATCHED   = 2'b11    // latched off until supply collapses or mains drops
    } prot_state_t;

endpackage

// *** core/gate_timing_if.sv ***
// Purpose : carries gate timing events between the window timer and the top
// Assumes : single clock domain
// Notes   : window signals are flip-flop pulses or levels; turn_off_pulse is combinational
`timescale 1ns/1ps
interface gate_timing_if;
    logic turn_off_pulse;   // gate fell this cycle
    logic window_open;      // sampling window level
    logic window_close;     // one-cycle pulse at window end

    modport timer (output window_open, output window_close, input turn_off_pulse);
    modport user  (input window_open, input window_close, output turn_off_pulse);
endinterface

// *** core/ovp_window_timer.sv ***
// Purpose : blanking delay and sampling window after each switch turn-off
// Assumes : turn_off_pulse is one cycle long
// Notes   : a new turn-off restarts the sequence from the beginning
`timescale 1ns/1ps
module ovp_window_timer
    import prot_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // timing events
    gate_timing_if.timer    tmg
);

    // ****************************************
    // phase counter
    // ****************************************
    logic [TIMER_W-1:0] count_reg;     // cycles left in current phase
    logic               blank_reg;     // blanking phase active
    logic               open_reg;      // window phase active
    logic               close_reg;     // end-of-window pulse

    // blanking then window, both counted in clock cycles
    always_ff @(posedge clock) begin
        if (srst) begin
            count_reg <= '0;
            blank_reg <= 1'b0;
            open_reg  <= 1'b0;
            close_reg <= 1'b0;
        end else begin
            close_reg <= 1'b0;
            if (tmg.turn_off_pulse) begin
                // restart: rejects the spike on the rising auxiliary edge
                count_reg <= BLANK_CYCLES - TIMER_W'(1);   // [R2] [R15]
                blank_reg <= 1'b1;
                open_reg  <= 1'b0;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - TIMER_W'(1);
            end else if (blank_reg) begin
                // blanking over, open the window
                blank_reg <= 1'b0;
                open_reg  <= 1'b1;
                count_reg <= WINDOW_CYCLES - TIMER_W'(1);  // [R2] [R15]
            end else if (open_reg) begin
                // window over, report end of this cycle's check
                open_reg  <= 1'b0;
                close_reg <= 1'b1;
            end
        end
    end

    assign tmg.window_open  = open_reg;
    assign tmg.window_close = close_reg;

endmodule

// *** tb/ovp_brownout_protection_properties.sv ***
// Purpose : port-level checks for the protection block
// Assumes : one clock, srst synchronous active high
// Notes   : a comparator change shows at the outputs three edges later
`timescale 1ns/1ps
module ovp_brownout_protection_properties (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // link inputs
    input wire logic gate_on,
    input wire logic aux_winding_sense,
    input wire logic feedforward_pin,
    input wire logic mains_above_upper,
    input wire logic mains_below_lower,
    input wire logic supply_below_5v,
    input wire logic supply_uvlo,
    // protection outputs
    input wire logic gate_enable,
    input wire logic gate_out,
    input wire logic feedforward_source_en,
    input wire logic mains_fail_flag,
    input wire logic mains_sink_en,
    input wire logic pfc_supply_switch,
    input wire logic softstart_discharge,
    input wire logic hv_startup_cycle,
    input wire logic latched_off,
    input wire logic ovp_stopped
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_gate_only_run: assert property (
        gate_out == (gate_on && gate_enable)) else $error("gate passed outside run");
    a_sink_tracks_flag: assert property (
        mains_sink_en == mains_fail_flag) else $error("mains sink differs from fail flag");
    a_brownout_outputs: assert property (
        mains_fail_flag |-> softstart_discharge && !pfc_supply_switch && !gate_enable)
        else $error("brownout outputs wrong");
    a_idle_hv_cycle: assert property (
        hv_startup_cycle == !gate_enable) else $error("startup cycling wrong");
    a_ovp_source_on: assert property (
        ovp_stopped |-> feedforward_source_en && !gate_enable) else $error("source off in stop");
    a_start_needs_mains: assert property (
        $rose(gate_enable) |-> $past(mains_above_upper, 3) && !$past(mains_below_lower, 3))
        else $error("started without mains");
    a_run_to_brownout: assert property (
        (gate_enable && mains_below_lower) [*3] |=> mains_fail_flag)
        else $error("no brownout on low mains");
    a_uvlo_forces_off: assert property (
        supply_uvlo [*3] |=> mains_fail_flag && !latched_off) else $error("lockout ignored");
    a_latch_holds: assert property (
        (latched_off && !supply_uvlo && !mains_below_lower) [*3] |=> latched_off)
        else $error("latch released early");
    a_latch_escalate: assert property (
        (ovp_stopped && feedforward_pin && !supply_uvlo && !supply_below_5v
         && !mains_below_lower) [*3] |=> latched_off) else $error("no escalation");
endmodule

bind ovp_brownout_protection ovp_brownout_protection_properties u_props (
    .clock(clock), .srst(srst), .gate_on(gate_on), .aux_winding_sense(aux_winding_sense),
    .feedforward_pin(feedforward_pin), .mains_above_upper(mains_above_upper),
    .mains_below_lower(mains_below_lower), .supply_below_5v(supply_below_5v),
    .supply_uvlo(supply_uvlo), .gate_enable(gate_enable), .gate_out(gate_out),
    .feedforward_source_en(feedforward_source_en), .mains_fail_flag(mains_fail_flag),
    .mains_sink_en(mains_sink_en), .pfc_supply_switch(pfc_supply_switch),
    .softstart_discharge(softstart_discharge), .hv_startup_cycle(hv_startup_cycle),
    .latched_off(latched_off), .ovp_stopped(ovp_stopped));

// *** tb/analog_partner_model.sv ***
// Purpose : far side: comparators, pwm gate request, supply monitors
// Assumes : bench gives levels in millivolts
// Notes   : feedforward pin charges only while the source is on
`timescale 1ns/1ps
module analog_partner_model #(
    parameter int PERIOD  = 700,  // switching period, cycles
    parameter int ON_CYC  = 50,   // on-time, cycles
    parameter int FF_RISE = 40,   // source time to escalation level
    parameter int UVLO_MV = 4000  // lockout level, plain default
) (
    // clock
    input  wire logic        clock,
    // bench controls
    input  wire logic [15:0] mains_mv,
    input  wire logic [15:0] vcc_mv,
    input  wire logic [1:0]  aux_mode,
    input  wire logic        ff_clamp,
    input  wire logic        feedforward_source_en,
    // toward the block
    output logic             gate_on,
    output logic             aux_winding_sense,
    output logic             feedforward_pin,
    output logic             mains_above_upper,
    output logic             mains_below_lower,
    output logic             supply_below_5v,
    output logic             supply_uvlo
);
    logic [9:0] cnt_reg = 10'h000;  // place in the period
    logic [7:0] ff_reg  = 8'h00;    // charge time of the pin
    int         off;                // cycles since turn-off
    // free running period, so windows keep their spacing
    always_ff @(posedge clock) begin
        cnt_reg <= (cnt_reg == 10'(PERIOD - 1)) ? 10'h000 : cnt_reg + 10'h001;
    end
    // source charges the pin; a clamp stands for a low impedance
    always_ff @(posedge clock) begin
        if (!feedforward_source_en) begin
            ff_reg <= 8'h00;
        end else if (!ff_clamp && ff_reg != 8'hFF) begin
            ff_reg <= ff_reg + 8'h01;
        end
    end
    assign off = int'(cnt_reg) - ON_CYC;
    assign gate_on = cnt_reg < 10'(ON_CYC);
    // 1: inside window, 2: on-time only, 3: blanking only
    assign aux_winding_sense = (aux_mode == 2'h1 && off >= 515 && off <= 580)
                            || (aux_mode == 2'h2 && gate_on)
                            || (aux_mode == 2'h3 && off >= 100 && off <= 400);
    assign feedforward_pin   = ff_reg >= 8'(FF_RISE);
    assign mains_above_upper = mains_mv > 16'h01E5;
    assign mains_below_lower = mains_mv < 16'h01C2;
    assign supply_below_5v   = vcc_mv < 16'h1388;
    assign supply_uvlo       = vcc_mv < 16'(UVLO_MV);
endmodule

// *** tb/ovp_brownout_protection_tb_top.sv ***
// Purpose : self-checking bench for the protection block
// Assumes : partner model supplies gate timing and comparators
// Notes   : fixed seed, so every run repeats
`timescale 1ns/1ps
module ovp_brownout_protection_tb_top import prot_pkg::*; ;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] mains_mv = 16'h012C;  // bench levels, mV
    logic [15:0] vcc_mv = 16'h2EE0;
    logic [1:0]  aux_mode = 2'h0;
    logic        ff_clamp = 1'b1;
    logic        gate_on, aux_winding_sense, feedforward_pin, mains_above_upper;
    logic        mains_below_lower, supply_below_5v, supply_uvlo, gate_enable, gate_out;
    logic        feedforward_source_en, mains_fail_flag, mains_sink_en, pfc_supply_switch;
    logic        softstart_discharge, hv_startup_cycle, latched_off, ovp_stopped;
    logic [15:0] m;                    // random mains level
    integer      seed = 30;
    int          num_errors = 0;
    int          checked = 0;
    always #(CLK_PERIOD_NS / 2) clock = ~clock;
    ovp_brownout_protection dut (
        .clock(clock), .srst(srst), .gate_on(gate_on), .aux_winding_sense(aux_winding_sense),
        .feedforward_pin(feedforward_pin), .mains_above_upper(mains_above_upper),
        .mains_below_lower(mains_below_lower), .supply_below_5v(supply_below_5v),
        .supply_uvlo(supply_uvlo), .gate_enable(gate_enable), .gate_out(gate_out),
        .feedforward_source_en(feedforward_source_en), .mains_fail_flag(mains_fail_flag),
        .mains_sink_en(mains_sink_en), .pfc_supply_switch(pfc_supply_switch),
        .softstart_discharge(softstart_discharge), .hv_startup_cycle(hv_startup_cycle),
        .latched_off(latched_off), .ovp_stopped(ovp_stopped));
    analog_partner_model partner (
        .clock(clock), .mains_mv(mains_mv), .vcc_mv(vcc_mv), .aux_mode(aux_mode),
        .ff_clamp(ff_clamp), .feedforward_source_en(feedforward_source_en),
        .gate_on(gate_on), .aux_winding_sense(aux_winding_sense),
        .feedforward_pin(feedforward_pin), .mains_above_upper(mains_above_upper),
        .mains_below_lower(mains_below_lower), .supply_below_5v(supply_below_5v),
        .supply_uvlo(supply_uvlo));
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // brownout expected from mains level and run status
    function automatic logic exp_brownout(input logic [15:0] mv, input logic running);
        return running ? (mv < 16'h01C2) : (mv <= 16'h01E5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // new levels, then settle well past the three-edge latency
    task automatic set_lv(input logic [15:0] mv, input logic [15:0] vv);
        @(posedge clock);
        mains_mv <= mv;
        vcc_mv   <= vv;
        cyc(8);
    endtask
    // one switching period with the given aux pattern
    task automatic period(input logic [1:0] mode);
        do @(negedge clock); while (gate_on !== 1'b1);
        @(posedge clock);
        aux_mode <= mode;
        do @(negedge clock); while (gate_on !== 1'b0);
        do @(negedge clock); while (gate_on !== 1'b1);
    endtask
    task automatic trip();
        repeat (4) period(2'h1);
        @(posedge clock);
        aux_mode <= 2'h0;
        cyc(60);
    endtask
    task automatic final_report();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin : main
        int r;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        // mains between thresholds before start: no start
        for (int i = 0; i < 3; i++) begin
            m = 16'h01C3 + 16'($random(seed) & 32'h1F);
            set_lv(m, 16'h2EE0);
            check("mains_fail_flag", mains_fail_flag, exp_brownout(m, 1'b0));
            check("hv_startup_cycle", hv_startup_cycle, 1'b1);
        end
        set_lv(16'h0258, 16'h2EE0);
        check("gate_enable", gate_enable, 1'b1);
        check("pfc_supply_switch", pfc_supply_switch, 1'b1);
        // same band while running: keeps running
        m = 16'h01C3 + 16'($random(seed) & 32'h1F);
        set_lv(m, 16'h2EE0);
        check("gate_enable", gate_enable, !exp_brownout(m, 1'b1));
        // three hits, a miss, three hits: no stop
        repeat (3) period(2'h1);
        r = $unsigned($random(seed)) % 3;
        period((r == 0) ? 2'h0 : 2'(r + 1));
        repeat (3) period(2'h1);
        check("ovp_stopped", ovp_stopped, 1'b0);
        // fourth hit trips; clamped pin gives auto-restart
        trip();
        check("ovp_stopped", ovp_stopped, 1'b1);
        check("feedforward_source_en", feedforward_source_en, 1'b1);
        check("gate_out", gate_out, 1'b0);
        set_lv(16'h0258, 16'h12C0);
        check("gate_enable", gate_enable, 1'b1);
        set_lv(16'h0258, 16'h2EE0);
        // unclamped pin escalates to the latch, mains drop clears it
        @(posedge clock);
        ff_clamp <= 1'b0;
        trip();
        check("latched_off", latched_off, 1'b1);
        cyc(300);
        check("latched_off", latched_off, 1'b1);
        set_lv(16'h012C, 16'h2EE0);
        check("latched_off", latched_off, 1'b0);
        check("mains_sink_en", mains_sink_en, 1'b1);
        check("softstart_discharge", softstart_discharge, 1'b1);
        set_lv(16'h0258, 16'h2EE0);
        // latch again, cleared by lockout
        trip();
        set_lv(16'h0258, 16'h07D0);
        check("latched_off", latched_off, 1'b0);
        set_lv(16'h0258, 16'h2EE0);
        // running, mains under lower threshold
        m = 16'h0190 + 16'($random(seed) & 32'h1F);
        set_lv(m, 16'h2EE0);
        check("mains_fail_flag", mains_fail_flag, exp_brownout(m, 1'b1));
        check("mains_sink_en", mains_sink_en, 1'b1);
        final_report();
    end
    // hang guard, about three times the expected run
    initial begin : watchdog
        repeat (40000) @(posedge clock);
        num_errors++;
        final_report();
    end
endmodule
